// *** rtl/acr_consts.svh ***
// Constants for the converter control and result register block.
// Assumes a classic Wishbone slave on a 125 MHz core clock.
//
// Summary of operation
// - Channel field picks inputs or references
// - Writing go with enable set starts conversion, reads busy
// - Hardware clears go at completion
// - Go reads zero when idle
// - Enable bit powers converter, off otherwise
// - Left format: high 9..2, low 1..0 top
// - Right format: high 9..8 low, low 7..0
// - Result registers read-only, zero before first conversion
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH
`define ACR_ADDR_W 4
`define ACR_OFF_CTRL 4'h0
`define ACR_OFF_RESH 4'h4
`define ACR_OFF_RESL 4'h8
`define ACR_OFF_IRQ_STAT 4'hc
`define ACR_OFF_IRQ_MASK 4'h1
`define ACR_CTRL_FMT 7
`define ACR_CTRL_VREF 6
`define ACR_CTRL_CHS_HI 4
`define ACR_CTRL_CHS_LO 2
`define ACR_CTRL_GO 1
`define ACR_CTRL_EN 0
`define ACR_CTRL_RST 8'h00
`define ACR_CTRL_WMASK 8'hdf
`define ACR_CONV_CYCLES 6'h28
`define ACR_STEP_RELOAD 6'h03
`define ACR_CNT_W 6
`define ACR_IRQ_DONE 0
`define ACR_IRQ_ABORT 1
`endif

// *** rtl/acr_pkg.sv ***
// Types for the converter control and result register block.
// Assumes the constants header is included alongside.
package acr_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [7:0] dat;
  } acr_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [7:0] dat;
  } acr_wb_rsp_t;
  typedef struct packed {
    logic [2:0] input_select;
    logic converter_enable;
    logic vref_pin;
  } acr_ana_ctl_t;
  typedef enum logic [1:0] {
    ACR_SRC_ANALOG,
    ACR_SRC_COMP_REF,
    ACR_SRC_REF_0P6,
    ACR_SRC_REF_1P2
  } acr_src_t;
endpackage

// *** rtl/acr_sar.sv ***
// Successive-approximation sequencer: one result bit per step.
// Assumes comp_hi compares the hold node against the trial code dac.
`timescale 1ns/1ps
`include "acr_consts.svh"
module acr_sar (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  input wire logic comp_hi,
  output logic [9:0] dac,
  output logic busy,
  output logic done,
  output logic [9:0] value
);
  logic [9:0] trial_reg;
  logic [9:0] bit_reg;
  logic [`ACR_CNT_W-1:0] cnt_reg;
  logic busy_reg;
  wire step = busy_reg && (cnt_reg == '0);
  wire last = bit_reg[0];
  wire [9:0] kept = comp_hi ? trial_reg : (trial_reg & ~bit_reg);
  // Settling spread over several clocks per bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trial_reg <= 10'h000;
      bit_reg <= 10'h000;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      if (abort) begin
        busy_reg <= 1'b0;
      end else if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        bit_reg <= 10'h200;
        trial_reg <= 10'h200;
        cnt_reg <= `ACR_STEP_RELOAD;
      end else if (busy_reg) begin
        cnt_reg <= (cnt_reg == '0) ? `ACR_STEP_RELOAD : cnt_reg - 6'h01;
        if (step) begin
          trial_reg <= kept | (bit_reg >> 1);
          bit_reg <= bit_reg >> 1;
          if (last) begin
            busy_reg <= 1'b0;
            trial_reg <= kept;
          end
        end
      end
    end
  end
  assign dac = trial_reg;
  assign busy = busy_reg;
  // Done marks the last step, so the result lands as busy falls
  assign done = step && last && !abort;
  assign value = kept;
endmodule // acr_sar

// *** rtl/acr_top.sv ***
// Register front end: control, result bytes, interrupt status and mask.
// Assumes classic Wishbone master, 8-bit data, byte index times four except mask at offset 1.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "acr_consts.svh"
module acr_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire acr_pkg::acr_wb_req_t wb_req,
  input wire logic comp_hi,
  output acr_pkg::acr_wb_rsp_t wb_rsp,
  output acr_pkg::acr_ana_ctl_t ana_ctl,
  output logic [9:0] dac,
  output logic irq
);
  import acr_pkg::*;
  logic [7:0] ctrl_reg;
  logic [9:0] value_reg;
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [1:0] mask_reg;
  logic ack_reg;
  logic [7:0] rdat_reg;
  logic irq_reg;
  acr_ana_ctl_t ana_reg;
  logic [9:0] dac_reg;
  logic sar_busy;
  logic sar_done;
  logic [9:0] sar_value;
  logic [9:0] sar_dac;

  wire req = wb_req.cyc && wb_req.stb && !ack_reg;
  wire wr = req && wb_req.we;
  wire hit_ctrl = wb_req.adr == `ACR_OFF_CTRL;
  wire hit_resh = wb_req.adr == `ACR_OFF_RESH;
  wire hit_resl = wb_req.adr == `ACR_OFF_RESL;
  wire hit_stat = wb_req.adr == `ACR_OFF_IRQ_STAT;
  wire hit_mask = wb_req.adr == `ACR_OFF_IRQ_MASK;
  wire wr_ctrl = wr && hit_ctrl;
  wire enabled = ctrl_reg[`ACR_CTRL_EN];
  wire fmt_right = ctrl_reg[`ACR_CTRL_FMT];
  // Go is accepted only with the converter on
  wire go_set = wr_ctrl && wb_req.dat[`ACR_CTRL_GO] && enabled;
  // Turning the converter off mid-cycle kills the cycle
  wire abort = sar_busy && wr_ctrl && !wb_req.dat[`ACR_CTRL_EN];
  // Format applies at read time, so flipping it re-presents old data
  wire [7:0] resh = fmt_right ? {6'h00, value_reg[9:8]}
                              : value_reg[9:2];
  wire [7:0] resl = fmt_right ? value_reg[7:0]
                              : {value_reg[1:0], 6'h00};
  wire [7:0] ctrl_rd = {ctrl_reg[7:6], 1'b0, ctrl_reg[4:2], sar_busy,
                        ctrl_reg[0]};
  wire [7:0] rd_mux = hit_ctrl ? ctrl_rd :
                      hit_resh ? resh :
                      hit_resl ? resl :
                      hit_stat ? {6'h00, stat_reg} :
                      hit_mask ? {6'h00, mask_reg} : 8'h00;
  wire [1:0] events = {abort, sar_done};

  // Set wins over write-one-to-clear
  always_comb begin
    stat_next = stat_reg;
    if (wr && hit_stat) begin
      stat_next = stat_reg & ~wb_req.dat[1:0];
    end
    stat_next = stat_next | events;
  end

  acr_sar u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(go_set),
    .abort(abort),
    .comp_hi(comp_hi),
    .dac(sar_dac),
    .busy(sar_busy),
    .done(sar_done),
    .value(sar_value)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `ACR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= wb_req.dat & `ACR_CTRL_WMASK;
    end
  end

  // Result only moves at completion; reads before that return the previous result or the reset zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_reg <= 10'h000;
    end else if (sar_done) begin
      value_reg <= sar_value;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_reg <= 2'h0;
      mask_reg <= 2'h0;
    end else begin
      stat_reg <= stat_next;
      if (wr && hit_mask) begin
        mask_reg <= wb_req.dat[1:0];
      end
    end
  end

  // One-cycle answer; result writes are dropped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 8'h00;
    end else begin
      ack_reg <= req;
      rdat_reg <= req ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
      ana_reg <= '0;
      dac_reg <= 10'h000;
    end else begin
      irq_reg <= |(stat_next & mask_reg);
      ana_reg.input_select <= ctrl_reg[`ACR_CTRL_CHS_HI:`ACR_CTRL_CHS_LO];
      ana_reg.converter_enable <= enabled;
      ana_reg.vref_pin <= ctrl_reg[`ACR_CTRL_VREF];
      dac_reg <= sar_dac;
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdat_reg;
  assign ana_ctl = ana_reg;
  assign dac = dac_reg;
  assign irq = irq_reg;

  // Source classification for the analog mux, reference codes 100..111
  wire [2:0] sel = ctrl_reg[`ACR_CTRL_CHS_HI:`ACR_CTRL_CHS_LO];
  acr_src_t src;
  assign src = !sel[2] ? ACR_SRC_ANALOG :
               (sel == 3'h4) ? ACR_SRC_COMP_REF :
               (sel == 3'h5) ? ACR_SRC_REF_0P6 : ACR_SRC_REF_1P2;

  property p_go_reads_busy;
    @(posedge clk) disable iff (sys_rst)
      go_set |=> sar_busy && ctrl_rd[`ACR_CTRL_GO];
  endproperty
  a_go_reads_busy: assert property (p_go_reads_busy)
    else $error("go not busy after start");

  property p_done_clears;
    @(posedge clk) disable iff (sys_rst)
      sar_done |=> !sar_busy && !ctrl_rd[`ACR_CTRL_GO];
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("go still set at completion");

  property p_idle_zero;
    @(posedge clk) disable iff (sys_rst)
      !sar_busy |-> !ctrl_rd[`ACR_CTRL_GO];
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("go set while idle");

  property p_off_no_conv;
    @(posedge clk) disable iff (sys_rst)
      !enabled |=> !sar_busy;
  endproperty
  a_off_no_conv: assert property (p_off_no_conv)
    else $error("conversion while disabled");

  property p_left;
    @(posedge clk) disable iff (sys_rst)
      !fmt_right |-> resh == value_reg[9:2] && resl[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left)
    else $error("left format wrong");

  property p_right;
    @(posedge clk) disable iff (sys_rst)
      fmt_right |-> resh[7:2] == 6'h00 && resl == value_reg[7:0];
  endproperty
  a_right: assert property (p_right)
    else $error("right format wrong");

  property p_ro;
    @(posedge clk) disable iff (sys_rst)
      wr && (hit_resh || hit_resl) && !sar_done |=> $stable(value_reg);
  endproperty
  a_ro: assert property (p_ro)
    else $error("result changed by write");

  property p_load;
    @(posedge clk) disable iff (sys_rst)
      sar_done |=> value_reg == $past(sar_value);
  endproperty
  a_load: assert property (p_load)
    else $error("result not loaded");

  property p_sel;
    @(posedge clk) disable iff (sys_rst)
      sel == 3'h5 |-> src == ACR_SRC_REF_0P6;
  endproperty
  a_sel: assert property (p_sel)
    else $error("select decode wrong");

  property p_ack_drop;
    @(posedge clk) disable iff (sys_rst)
      ack_reg |=> !ack_reg;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack held two cycles");

  // Cycles since start, to check the conversion length
  logic [5:0] run_cnt_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cnt_reg <= 6'h00;
    end else if (go_set && !sar_busy) begin
      run_cnt_reg <= 6'h00;
    end else if (sar_busy) begin
      run_cnt_reg <= run_cnt_reg + 6'h01;
    end
  end

  property p_conv_len;
    @(posedge clk) disable iff (sys_rst)
      sar_done |-> run_cnt_reg == `ACR_CONV_CYCLES - 6'h01;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_busy_hold;
    @(posedge clk) disable iff (sys_rst)
      sar_busy && !abort && !sar_done |=> sar_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");

  property p_busy_on;
    @(posedge clk) disable iff (sys_rst)
      sar_busy |-> enabled;
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("busy with converter off");

  property p_go_off;
    @(posedge clk) disable iff (sys_rst)
      wr_ctrl && !enabled |=> !sar_busy;
  endproperty
  a_go_off: assert property (p_go_off)
    else $error("go taken while off");

  property p_ctrl_write;
    @(posedge clk) disable iff (sys_rst)
      wr_ctrl |=> ctrl_reg[7:6] == $past(wb_req.dat[7:6]) &&
        sel == $past(wb_req.dat[4:2]) && enabled == $past(wb_req.dat[0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write lost");

  property p_ana_follow;
    @(posedge clk) disable iff (sys_rst)
      $stable(ctrl_reg) |-> ana_reg.input_select == sel &&
        ana_reg.converter_enable == enabled;
  endproperty
  a_ana_follow: assert property (p_ana_follow)
    else $error("analog control stale");

  property p_idle_read;
    @(posedge clk) disable iff (sys_rst)
      req && !wb_req.we && hit_ctrl && !sar_busy |=>
        !rdat_reg[`ACR_CTRL_GO];
  endproperty
  a_idle_read: assert property (p_idle_read)
    else $error("go read one while idle");

  property p_left_low;
    @(posedge clk) disable iff (sys_rst)
      req && !wb_req.we && hit_resl && !fmt_right |=> rdat_reg[5:0] == 6'h00;
  endproperty
  a_left_low: assert property (p_left_low)
    else $error("left low byte padding wrong");

  property p_right_high;
    @(posedge clk) disable iff (sys_rst)
      req && !wb_req.we && hit_resh && fmt_right |=> rdat_reg[7:2] == 6'h00;
  endproperty
  a_right_high: assert property (p_right_high)
    else $error("right high byte padding wrong");

  property p_done_flag;
    @(posedge clk) disable iff (sys_rst)
      sar_done |=> stat_reg[`ACR_IRQ_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done status not set");

  property p_abort_flag;
    @(posedge clk) disable iff (sys_rst)
      abort |=> stat_reg[`ACR_IRQ_ABORT];
  endproperty
  a_abort_flag: assert property (p_abort_flag)
    else $error("abort status not set");

  property p_w1c;
    @(posedge clk) disable iff (sys_rst)
      wr && hit_stat && wb_req.dat[0] && !sar_done |=> !stat_reg[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status not cleared");

  property p_sticky;
    @(posedge clk) disable iff (sys_rst)
      stat_reg[0] && !(wr && hit_stat && wb_req.dat[0]) |=> stat_reg[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status lost without clear");

  property p_irq_on;
    @(posedge clk) disable iff (sys_rst)
      |(stat_reg & mask_reg) && !(wr && (hit_stat || hit_mask)) |=> irq_reg;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("irq missing");

  property p_irq_off;
    @(posedge clk) disable iff (sys_rst)
      (stat_reg & mask_reg) == 2'h0 && events == 2'h0 |=> !irq_reg;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq without cause");

  property p_ack_req;
    @(posedge clk) disable iff (sys_rst)
      req |=> ack_reg;
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("request not acked");

  property p_unmapped;
    @(posedge clk) disable iff (sys_rst)
      req && !wb_req.we &&
        !(hit_ctrl || hit_resh || hit_resl || hit_stat || hit_mask) |=>
        rdat_reg == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  c_conv: cover property (@(posedge clk) disable iff (sys_rst)
    go_set ##[1:60] sar_done);
  c_abort: cover property (@(posedge clk) disable iff (sys_rst) abort);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) irq_reg);
  c_right: cover property (@(posedge clk) disable iff (sys_rst)
    ack_reg && fmt_right);
endmodule // acr_top

// *** verification/acr_testbench.sv ***
// Self-checking bench for the converter control and result registers.
// Assumes acr_top answers classic Wishbone with a registered ack.
`timescale 1ns/1ps
`include "acr_consts.svh"
module testbench;
  import acr_pkg::*;
  logic clk;
  logic sys_rst;
  acr_wb_req_t wb_req;
  acr_wb_rsp_t wb_rsp;
  acr_ana_ctl_t ana_ctl;
  logic comp_hi;
  logic [9:0] dac;
  logic irq;
  logic [9:0] target;
  logic [7:0] rd;
  int n_mismatch;
  int num_checks;
  // Control write value beside its expected read back
  logic [15:0] rows [10] = '{16'h0200, 16'h0101, 16'h0505, 16'h0909,
    16'h0d0d, 16'h1111, 16'h1515, 16'h1919, 16'hfddd, 16'h0000};
  acr_top dut (.clk(clk), .sys_rst(sys_rst), .wb_req(wb_req),
    .comp_hi(comp_hi), .wb_rsp(wb_rsp), .ana_ctl(ana_ctl), .dac(dac),
    .irq(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Comparator stand-in; its lag fits inside four cycles a bit
  always @(posedge clk) begin
    comp_hi <= (target >= dac);
  end
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr,
      input logic [7:0] dat, output logic [7:0] q);
    int i;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat};
    q = 8'hxx;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_rsp.ack === 1'b1) begin
        q = wb_rsp.dat;
        break;
      end
    end
    if (i == 20) n_mismatch++;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
    wb(1'b1, adr, dat, rd);
  endtask
  task automatic rdchk(input logic [3:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00, rd);
    chk(rd, exp);
  endtask
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, {7'h00, exp});
  endtask
  task automatic conv(input logic [9:0] tgt, input logic fmt);
    logic [7:0] c;
    int i;
    c = {fmt, 7'h01};
    target <= tgt;
    wr(`ACR_OFF_CTRL, c);
    repeat (8) @(posedge clk);
    wr(`ACR_OFF_CTRL, c | 8'h02);
    rdchk(`ACR_OFF_CTRL, c | 8'h02);
    for (i = 0; i < 40; i++) begin
      wb(1'b0, `ACR_OFF_CTRL, 8'h00, rd);
      if (rd[1] === 1'b0) break;
    end
    chk(rd, c);
    if (fmt) begin
      rdchk(`ACR_OFF_RESH, {6'h00, tgt[9:8]});
      rdchk(`ACR_OFF_RESL, tgt[7:0]);
    end else begin
      rdchk(`ACR_OFF_RESH, tgt[9:2]);
      rdchk(`ACR_OFF_RESL, {tgt[1:0], 6'h00});
    end
    chk(dac[7:0], tgt[7:0]);
    chk({6'h00, dac[9:8]}, {6'h00, tgt[9:8]});
  endtask
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    wb_req = '0;
    comp_hi = 1'b0;
    target = 10'h000;
    sys_rst = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdchk(`ACR_OFF_CTRL, 8'h00);
    rdchk(`ACR_OFF_IRQ_STAT, 8'h00);
    rdchk(4'h1, 8'h00);
    irqchk(1'b0);
    foreach (rows[k]) begin
      wr(`ACR_OFF_CTRL, rows[k][15:8]);
      rdchk(`ACR_OFF_CTRL, rows[k][7:0]);
      chk({3'h0, ana_ctl.vref_pin, ana_ctl.input_select,
        ana_ctl.converter_enable}, {3'h0, rows[k][14], rows[k][12:10],
        rows[k][8]});
    end
    conv(10'h2d5, 1'b0);
    wr(`ACR_OFF_CTRL, 8'h81);
    rdchk(`ACR_OFF_RESH, 8'h02);
    rdchk(`ACR_OFF_RESL, 8'hd5);
    conv(10'h3ff, 1'b1);
    wr(`ACR_OFF_RESH, 8'h00);
    wr(`ACR_OFF_RESL, 8'h00);
    rdchk(`ACR_OFF_RESH, 8'h03);
    rdchk(`ACR_OFF_RESL, 8'hff);
    conv(10'h000, 1'b0);
    // Done left pending while masked out
    rdchk(`ACR_OFF_IRQ_STAT, 8'h01);
    irqchk(1'b0);
    wr(4'h1, 8'h01);
    irqchk(1'b1);
    wr(`ACR_OFF_IRQ_STAT, 8'h01);
    irqchk(1'b0);
    rdchk(`ACR_OFF_IRQ_STAT, 8'h00);
    // Disable in mid conversion aborts it
    wr(`ACR_OFF_CTRL, 8'h01);
    wr(`ACR_OFF_CTRL, 8'h03);
    wr(`ACR_OFF_CTRL, 8'h00);
    rdchk(`ACR_OFF_CTRL, 8'h00);
    rdchk(`ACR_OFF_IRQ_STAT, 8'h02);
    irqchk(1'b0);
    wr(4'h1, 8'h03);
    irqchk(1'b1);
    wr(`ACR_OFF_IRQ_STAT, 8'h02);
    irqchk(1'b0);
    // Reset in mid conversion returns every register to idle
    wr(`ACR_OFF_CTRL, 8'h01);
    wr(`ACR_OFF_CTRL, 8'h03);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdchk(`ACR_OFF_CTRL, 8'h00);
    rdchk(`ACR_OFF_IRQ_STAT, 8'h00);
    rdchk(4'h1, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, ana_ctl.converter_enable}, 8'h00);
    wr(4'h2, 8'hff);
    rdchk(4'h2, 8'h00);
    close_out();
  end
endmodule // testbench
